// [shared/kcs_map.vh]
`ifndef KCS_MAP_VH
`define KCS_MAP_VH

// Register addresses on the serial register bus
`define KCS_REG_SETUP 8'h07
`define KCS_REG_VERSION 8'h0b

// Field positions in the sounder setup register
`define KCS_BIT_ON 0
`define KCS_BIT_PITCH 1
`define KCS_BIT_LENGTH 2

// Reset value of the three setup bits
`define KCS_SETUP_RST 3'h0

// Default 7-bit bus address of the device
`define KCS_SLAVE_ADDR 7'h5c

// System clock rate
`define KCS_CLK_HZ 100000000

// Click lengths in ms, tone pitches in Hz
`define KCS_CLICK_SHORT_MS 10
`define KCS_CLICK_LONG_MS 20
`define KCS_TONE_LOW_HZ 1000
`define KCS_TONE_HIGH_HZ 2000

// The same timings in clk_sys cycles, sized to the counters that hold them
`define KCS_CLICK_SHORT_CYC 21'h0f4240
`define KCS_CLICK_LONG_CYC 21'h1e8480
`define KCS_HALF_LOW_CYC 16'hc350
`define KCS_HALF_HIGH_CYC 16'h61a8

// Last index of the version string (the zero byte)
`define KCS_VER_LAST 5'h1f

`endif

// [logic/kcs_sounder.v]
`timescale 1ns/10ps
`include "kcs_map.vh"

module kcs_sounder #(
  parameter [20:0] CLICK_SHORT_CYC = `KCS_CLICK_SHORT_CYC,
  parameter [20:0] CLICK_LONG_CYC = `KCS_CLICK_LONG_CYC,
  parameter [15:0] HALF_LOW_CYC = `KCS_HALF_LOW_CYC,
  parameter [15:0] HALF_HIGH_CYC = `KCS_HALF_HIGH_CYC
) (
  input wire clk_sys,
  input wire rstn,
  input wire tone_output_on,
  input wire tone_pitch_sel,
  input wire click_length_sel,
  input wire touch_detect,
  output wire sounder_out
);

  localparam [20:0] SHORT_LAST = CLICK_SHORT_CYC - 21'h000001;
  localparam [20:0] LONG_LAST = CLICK_LONG_CYC - 21'h000001;
  localparam [15:0] LOW_LAST = HALF_LOW_CYC - 16'h0001;
  localparam [15:0] HIGH_LAST = HALF_HIGH_CYC - 16'h0001;

  reg touch_q_ff;
  reg active_ff;
  reg [20:0] len_ff;
  reg [15:0] tone_cnt_ff;
  reg out_ff;
  wire touch_rise;
  wire [15:0] half_last;

  assign touch_rise = touch_detect & ~touch_q_ff;
  // Pitch follows the register live; a change mid-click just bends the tone
  assign half_last = tone_pitch_sel ? HIGH_LAST : LOW_LAST;
  assign sounder_out = out_ff;

  ////////////////////////////////////////////////////////////////////////
  // Click timer and square wave, free of any bus state
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      touch_q_ff <= 1'b0;
      active_ff <= 1'b0;
      len_ff <= 21'h000000;
      tone_cnt_ff <= 16'h0000;
      out_ff <= 1'b0;
    end else begin
      touch_q_ff <= touch_detect;
      if (!tone_output_on) begin
        active_ff <= 1'b0;
        out_ff <= 1'b0;
      end else if (!active_ff && touch_rise) begin
        active_ff <= 1'b1;
        len_ff <= click_length_sel ? LONG_LAST : SHORT_LAST;
        tone_cnt_ff <= 16'h0000;
        out_ff <= 1'b1;
      end else if (active_ff) begin
        if (len_ff == 21'h000000) begin
          active_ff <= 1'b0;
          out_ff <= 1'b0; // Idle low keeps no DC across the piezo
        end else begin
          len_ff <= len_ff - 21'h000001;
        end
        // Equal halves give 50 percent duty
        if (len_ff != 21'h000000) begin
          if (tone_cnt_ff >= half_last) begin
            tone_cnt_ff <= 16'h0000;
            out_ff <= ~out_ff;
          end else begin
            tone_cnt_ff <= tone_cnt_ff + 16'h0001;
          end
        end
      end
    end
  end

endmodule

// [logic/kcs_top.v]
// Behaviour
// - Sounder setup register answers at bus register address 0x07.
// - Setup bit 2 picks click length: clear 10 ms, set 20 ms.
// - Setup bit 1 picks tone: clear 1 kHz, set 2 kHz.
// - Setup bit 0 enables clicks; clear means no tone at all.
// - Click generation runs on its own, never waiting on bus traffic.
// - Sounder pin gives a push-pull drive fit for a piezo buzzer.
// - Version register at 0x0B is read-only, static; writes do nothing.
// - Burst reads of 0x0B return an ASCII version string ending in zero.
`timescale 1ns/10ps
`include "kcs_map.vh"

module kcs_top #(
  parameter [6:0] SLAVE_ADDR = `KCS_SLAVE_ADDR,
  parameter [20:0] CLICK_SHORT_CYC = `KCS_CLICK_SHORT_CYC,
  parameter [20:0] CLICK_LONG_CYC = `KCS_CLICK_LONG_CYC,
  parameter [15:0] HALF_LOW_CYC = `KCS_HALF_LOW_CYC,
  parameter [15:0] HALF_HIGH_CYC = `KCS_HALF_HIGH_CYC
) (
  input wire clk_sys,
  input wire rstn,
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe,
  input wire touch_detect,
  output wire sounder_out
);

  // Bus slave states
  localparam [6:0] ST_IDLE = 7'h01;
  localparam [6:0] ST_ADDR = 7'h02;
  localparam [6:0] ST_AACK = 7'h04;
  localparam [6:0] ST_RX = 7'h08;
  localparam [6:0] ST_RACK = 7'h10;
  localparam [6:0] ST_TX = 7'h20;
  localparam [6:0] ST_TACK = 7'h40;

  // Version text, contents arbitrary; last byte is the terminator
  localparam [255:0] VER_TEXT = {"VNDR,PN:PART,QUAL:ENG,VER:1_0_0", 8'h00};

  reg [2:0] scl_sync_ff;
  reg [2:0] sda_sync_ff;
  reg scl_st_ff;
  reg sda_st_ff;
  reg [6:0] state_ff;
  reg [3:0] bit_cnt_ff;
  reg [7:0] shift_ff;
  reg rw_ff;
  reg first_ff;
  reg mack_ff;
  reg sda_oe_ff;
  reg [7:0] ptr_ff;
  reg [4:0] str_idx_ff;
  reg [2:0] setup_ff;
  reg [6:0] nxt_state;
  reg [3:0] nxt_bit_cnt;
  reg [7:0] nxt_shift;
  reg nxt_rw;
  reg nxt_first;
  reg nxt_mack;
  reg nxt_sda_oe;
  reg [7:0] nxt_ptr;
  reg [4:0] nxt_str_idx;
  reg [2:0] nxt_setup;
  reg [7:0] tx_byte;
  wire scl_agree;
  wire sda_agree;
  wire scl_rise;
  wire scl_fall;
  wire bus_start;
  wire bus_stop;

  ////////////////////////////////////////////////////////////////////////
  // Byte the slave sends for a given register pointer
  function [7:0] kcs_read_byte;
    input [7:0] ptr;
    input [4:0] idx;
    input [2:0] setup;
    integer pos;
    begin
      pos = (31 - idx) * 8;
      if (ptr == `KCS_REG_SETUP) begin
        kcs_read_byte = {5'h00, setup};
      end else if (ptr == `KCS_REG_VERSION) begin
        kcs_read_byte = VER_TEXT[pos +: 8];
      end else begin
        kcs_read_byte = 8'h00;
      end
    end
  endfunction

  // Saturating step so a long burst keeps reading the zero byte
  function [4:0] kcs_next_idx;
    input [7:0] ptr;
    input [4:0] idx;
    begin
      if (ptr == `KCS_REG_VERSION && idx != `KCS_VER_LAST) begin
        kcs_next_idx = idx + 5'h01;
      end else begin
        kcs_next_idx = idx;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; a level counts once stages two and three agree
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      scl_sync_ff <= 3'h7;
      sda_sync_ff <= 3'h7;
      scl_st_ff <= 1'b1;
      sda_st_ff <= 1'b1;
    end else begin
      scl_sync_ff <= {scl_sync_ff[1:0], scl_in};
      sda_sync_ff <= {sda_sync_ff[1:0], sda_in};
      if (scl_agree) begin
        scl_st_ff <= scl_sync_ff[1];
      end
      if (sda_agree) begin
        sda_st_ff <= sda_sync_ff[1];
      end
    end
  end

  assign scl_agree = scl_sync_ff[1] == scl_sync_ff[2];
  assign sda_agree = sda_sync_ff[1] == sda_sync_ff[2];
  assign scl_rise = scl_agree & scl_sync_ff[1] & ~scl_st_ff;
  assign scl_fall = scl_agree & ~scl_sync_ff[1] & scl_st_ff;
  // Data edges only mean start or stop while the clock stays high
  assign bus_start = sda_agree & ~sda_sync_ff[1] & sda_st_ff & scl_st_ff & ~scl_fall;
  assign bus_stop = sda_agree & sda_sync_ff[1] & ~sda_st_ff & scl_st_ff & ~scl_fall;

  ////////////////////////////////////////////////////////////////////////
  // Bus slave next-state logic
  always @* begin
    nxt_state = state_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_shift = shift_ff;
    nxt_rw = rw_ff;
    nxt_first = first_ff;
    nxt_mack = mack_ff;
    nxt_sda_oe = sda_oe_ff;
    nxt_ptr = ptr_ff;
    nxt_str_idx = str_idx_ff;
    nxt_setup = setup_ff;
    tx_byte = kcs_read_byte(ptr_ff, str_idx_ff, setup_ff);
    if (bus_start) begin
      // Every start rewinds the version string to its first byte
      nxt_state = ST_ADDR;
      nxt_bit_cnt = 4'h0;
      nxt_sda_oe = 1'b0;
      nxt_str_idx = 5'h00;
    end else if (bus_stop) begin
      nxt_state = ST_IDLE;
      nxt_sda_oe = 1'b0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          nxt_sda_oe = 1'b0;
        end
        ST_ADDR: begin
          if (scl_rise) begin
            nxt_shift = {shift_ff[6:0], sda_st_ff};
            nxt_bit_cnt = bit_cnt_ff + 4'h1;
          end else if (scl_fall && bit_cnt_ff == 4'h8) begin
            if (shift_ff[7:1] == SLAVE_ADDR) begin
              nxt_rw = shift_ff[0];
              nxt_sda_oe = 1'b1;
              nxt_state = ST_AACK;
            end else begin
              nxt_state = ST_IDLE;
            end
          end
        end
        ST_AACK: begin
          if (scl_fall) begin
            nxt_bit_cnt = 4'h0;
            if (rw_ff) begin
              nxt_shift = tx_byte;
              nxt_sda_oe = ~tx_byte[7];
              nxt_str_idx = kcs_next_idx(ptr_ff, str_idx_ff);
              nxt_state = ST_TX;
            end else begin
              nxt_sda_oe = 1'b0;
              nxt_first = 1'b1;
              nxt_state = ST_RX;
            end
          end
        end
        ST_RX: begin
          if (scl_rise) begin
            nxt_shift = {shift_ff[6:0], sda_st_ff};
            nxt_bit_cnt = bit_cnt_ff + 4'h1;
          end else if (scl_fall && bit_cnt_ff == 4'h8) begin
            nxt_sda_oe = 1'b1;
            nxt_state = ST_RACK;
            if (first_ff) begin
              nxt_ptr = shift_ff;
              nxt_first = 1'b0;
              nxt_str_idx = 5'h00;
            end else if (ptr_ff == `KCS_REG_SETUP) begin
              nxt_setup = shift_ff[2:0];
            end
            // Writes to the version register are acknowledged and dropped
          end
        end
        ST_RACK: begin
          if (scl_fall) begin
            nxt_sda_oe = 1'b0;
            nxt_bit_cnt = 4'h0;
            nxt_state = ST_RX;
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            nxt_bit_cnt = bit_cnt_ff + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt_ff == 4'h8) begin
              nxt_sda_oe = 1'b0;
              nxt_state = ST_TACK;
            end else begin
              nxt_shift = {shift_ff[6:0], 1'b0};
              nxt_sda_oe = ~shift_ff[6];
            end
          end
        end
        ST_TACK: begin
          if (scl_rise) begin
            nxt_mack = ~sda_st_ff;
          end else if (scl_fall) begin
            if (mack_ff) begin
              nxt_shift = tx_byte;
              nxt_sda_oe = ~tx_byte[7];
              nxt_str_idx = kcs_next_idx(ptr_ff, str_idx_ff);
              nxt_bit_cnt = 4'h0;
              nxt_state = ST_TX;
            end else begin
              nxt_state = ST_IDLE;
            end
          end
        end
        default: begin
          nxt_state = ST_IDLE;
          nxt_sda_oe = 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus slave and register flops
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_ff <= ST_IDLE;
      bit_cnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      rw_ff <= 1'b0;
      first_ff <= 1'b0;
      mack_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      ptr_ff <= 8'h00;
      str_idx_ff <= 5'h00;
      setup_ff <= `KCS_SETUP_RST;
    end else begin
      state_ff <= nxt_state;
      bit_cnt_ff <= nxt_bit_cnt;
      shift_ff <= nxt_shift;
      rw_ff <= nxt_rw;
      first_ff <= nxt_first;
      mack_ff <= nxt_mack;
      sda_oe_ff <= nxt_sda_oe;
      ptr_ff <= nxt_ptr;
      str_idx_ff <= nxt_str_idx;
      setup_ff <= nxt_setup;
    end
  end

  // Open drain: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe = sda_oe_ff;

  ////////////////////////////////////////////////////////////////////////
  // Click generator; sees only the setup flops, so bus stalls cannot hold it
  kcs_sounder #(
    .CLICK_SHORT_CYC(CLICK_SHORT_CYC),
    .CLICK_LONG_CYC(CLICK_LONG_CYC),
    .HALF_LOW_CYC(HALF_LOW_CYC),
    .HALF_HIGH_CYC(HALF_HIGH_CYC)
  ) u_sounder (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .tone_output_on(setup_ff[`KCS_BIT_ON]),
    .tone_pitch_sel(setup_ff[`KCS_BIT_PITCH]),
    .click_length_sel(setup_ff[`KCS_BIT_LENGTH]),
    .touch_detect(touch_detect),
    .sounder_out(sounder_out)
  );

endmodule

// [sim/kcs_checker.sv]
`timescale 1ns/10ps
module kcs_checker #(
  parameter [20:0] CLICK_LONG_CYC = 21'h1e8480
) (
  input wire clk_sys,
  input wire rstn,
  input wire scl_in,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe,
  input wire touch_detect,
  input wire sounder_out
);
  reg touch_prev_ff;
  reg [21:0] since_touch_ff;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // Cycles since the last touch rise; saturates so idle stays idle
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      touch_prev_ff <= 1'b0;
      since_touch_ff <= 22'h3fffff;
    end else begin
      touch_prev_ff <= touch_detect;
      if (touch_detect && !touch_prev_ff)
        since_touch_ff <= 22'h0;
      else if (since_touch_ff != 22'h3fffff)
        since_touch_ff <= since_touch_ff + 22'h1;
    end
  end
  ////////////////////////////////////////
  // Sounder timing
  out_after_touch_a: assert property (sounder_out |-> since_touch_ff <= CLICK_LONG_CYC + 2)
    else $error("sounder active without a recent touch");
  half_high_a: assert property ($rose(sounder_out) |-> sounder_out[*5])
    else $error("tone high phase too short");
  half_low_a: assert property ($fell(sounder_out) |-> !sounder_out[*5])
    else $error("tone low phase too short");
  tone_toggle_a: assert property ($rose(sounder_out) |-> ##[5:11] !sounder_out)
    else $error("tone high phase too long");
  reset_quiet_a: assert property ($rose(rstn) |-> !sounder_out && !sda_oe)
    else $error("outputs active out of reset");
  ////////////////////////////////////////
  // Bus pin behaviour
  sda_const_a: assert property (sda_out == 1'b0)
    else $error("data pin value not low");
  oe_scl_low_a: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data drive changed while bus clock high");
  oe_hold_a: assert property ($rose(sda_oe) |-> sda_oe[*8])
    else $error("data drive released too early");
endmodule

bind kcs_top kcs_checker #(.CLICK_LONG_CYC(CLICK_LONG_CYC)) kcs_checker_inst (
  .clk_sys(clk_sys),
  .rstn(rstn),
  .scl_in(scl_in),
  .sda_in(sda_in),
  .sda_out(sda_out),
  .sda_oe(sda_oe),
  .touch_detect(touch_detect),
  .sounder_out(sounder_out)
);

// [sim/kcs_host.sv]
`timescale 1ns/10ps
module kcs_host (
  input wire clk_sys,
  input wire sda_in,
  output reg scl_out,
  output reg sda_low
);
  logic [7:0] rx [0:33];
  int nacks = 0;
  logic r;
  // Bus idle: clock high, data released
  initial begin
    scl_out = 1'b1;
    sda_low = 1'b0;
  end
  task tk(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // Data moves mid-low; sampled late in the high phase for margin
  task bitx(input logic b, output logic s);
    tk(5);
    sda_low <= !b;
    tk(5);
    scl_out <= 1'b1;
    tk(10);
    s = sda_in;
    scl_out <= 1'b0;
  endtask
  task start;
    tk(5);
    sda_low <= 1'b0;
    tk(5);
    scl_out <= 1'b1;
    tk(10);
    sda_low <= 1'b1;
    tk(10);
    scl_out <= 1'b0;
  endtask
  task stop;
    tk(5);
    sda_low <= 1'b1;
    tk(5);
    scl_out <= 1'b1;
    tk(10);
    sda_low <= 1'b0;
    tk(10);
  endtask
  task wr(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) bitx(b[i], r);
    bitx(1'b1, r);
    if (r) nacks++;
  endtask
  task rd(input int k, input logic last);
    for (int i = 7; i >= 0; i--) bitx(1'b1, rx[k][i]);
    bitx(last, r);
  endtask
  task wreg(input logic [7:0] p, input logic [7:0] d);
    start;
    wr(8'hb8);
    wr(p);
    wr(d);
    stop;
  endtask
  // Pointer write, repeated start, n bytes with the last one refused
  task rreg(input logic [7:0] p, input int n);
    start;
    wr(8'hb8);
    wr(p);
    start;
    wr(8'hb9);
    for (int k = 0; k < n; k++) rd(k, k == n - 1);
    stop;
  endtask
endmodule

// [sim/kcs_top_tb.sv]
`timescale 1ns/10ps
module kcs_top_tb;
  localparam string VER = "VNDR,PN:PART,QUAL:ENG,VER:1_0_0";
  logic clk_sys;
  logic rstn;
  logic touch_detect;
  wire scl_in;
  wire sda_low;
  wire sda_out;
  wire sda_oe;
  wire sounder_out;
  wire sda_in = !(sda_low || sda_oe);
  int n_fail = 0;
  int n_checks = 0;
  // Short click and tone counts keep the run brief
  kcs_top #(.CLICK_SHORT_CYC(21'hc8), .CLICK_LONG_CYC(21'h190), .HALF_LOW_CYC(16'ha), .HALF_HIGH_CYC(16'h5))
  kcs_top_inst (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .touch_detect(touch_detect),
    .sounder_out(sounder_out)
  );
  kcs_host kcs_host_inst (
    .clk_sys(clk_sys),
    .sda_in(sda_in),
    .scl_out(scl_in),
    .sda_low(sda_low)
  );
  ////////////////////////////////////////
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Write to the read-only place first, then read past the zero byte
  task t_regs;
    kcs_host_inst.wreg(8'h0b, 8'h55);
    kcs_host_inst.rreg(8'h0b, 34);
    for (int i = 0; i < 34; i++) begin
      chk("version byte", i < 31 ? VER[i] : 8'h00, kcs_host_inst.rx[i]);
    end
    kcs_host_inst.rreg(8'h03, 1);
    chk("unmapped byte", 8'h00, kcs_host_inst.rx[0]);
    chk("missed acks", 0, kcs_host_inst.nacks);
    // A foreign address must be left unanswered
    kcs_host_inst.start;
    kcs_host_inst.wr(8'hba);
    kcs_host_inst.stop;
    chk("foreign address nacks", 1, kcs_host_inst.nacks);
  endtask
  // Touch while the bus is busy; count tone periods of the click
  task t_click(input logic [2:0] s);
    int len;
    int half;
    int rises;
    int first;
    int last;
    logic prev;
    len = s[2] ? 400 : 200;
    half = s[1] ? 5 : 10;
    rises = 0;
    first = 0;
    last = 0;
    prev = 1'b0;
    kcs_host_inst.wreg(8'h07, {5'h1f, s});
    fork
      kcs_host_inst.rreg(8'h07, 1);
      begin
        @(posedge clk_sys);
        touch_detect <= 1'b1;
        for (int c = 1; c < 600; c++) begin
          @(posedge clk_sys);
          #1;
          if (sounder_out && !prev) rises++;
          if (sounder_out && !prev && first == 0) first = c;
          if (!sounder_out && prev) last = c;
          prev = sounder_out;
        end
        @(posedge clk_sys);
        touch_detect <= 1'b0;
      end
    join
    chk("setup readback", {5'h0, s}, kcs_host_inst.rx[0]);
    chk("tone periods", s[0] ? len / (2 * half) : 0, rises);
    if (s[0]) begin
      chk("click start", 1, first == 1 || first == 2);
      chk("click span", 1, last - first >= len - half && last - first <= len);
    end
  endtask
  // Reset in mid-run clears the setup
  task t_reset;
    kcs_host_inst.wreg(8'h07, 8'h07);
    @(posedge clk_sys);
    rstn <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (5) @(posedge clk_sys);
    kcs_host_inst.rreg(8'h07, 1);
    chk("setup after reset", 8'h00, kcs_host_inst.rx[0]);
  endtask
  ////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Main sequence
  initial begin
    rstn = 1'b0;
    touch_detect = 1'b0;
    repeat (10) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (5) @(posedge clk_sys);
    t_regs;
    for (int m = 0; m < 8; m++) t_click(m[2:0]);
    t_reset;
    conclude;
  end
  // Watchdog, about three times the expected run
  initial begin
    repeat (60000) @(posedge clk_sys);
    n_fail++;
    conclude;
  end
endmodule
